//--- sfr_pkg.sv
`default_nettype none
package sfr_pkg;

	// ***************************************************************
	// opcodes
	// ***************************************************************
	localparam logic [7:0] OP_FAST_READ = 8'h0b;
	localparam logic [7:0] OP_FAST_READ_WIDE = 8'h0c;
	localparam logic [7:0] OP_DUAL_IO = 8'hbb;
	localparam logic [7:0] OP_DUAL_IO_WIDE = 8'hbc;
	localparam logic [7:0] OP_QUAD_IO = 8'heb;
	localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
	localparam logic [7:0] OP_INFO_ROW = 8'h68;

	// ***************************************************************
	// frame timing in link clocks, address lengths in bits
	// ***************************************************************
	localparam logic [5:0] CMD_CYCLES_SINGLE = 6'h08;
	localparam logic [5:0] CMD_CYCLES_QUAD = 6'h02;
	localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
	localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
	localparam logic [5:0] MODE_CYCLES = 6'h04;
	localparam logic [4:0] DUMMY_SINGLE_DEFAULT = 5'h08;
	localparam logic [4:0] DUMMY_DUAL_DEFAULT = 5'h04;
	localparam logic [4:0] DUMMY_QUAD_DEFAULT = 5'h06;
	localparam logic [3:0] MODE_CONT_NIBBLE = 4'ha;
	localparam int ADDR_BITS_DEFAULT = 25;

	// ***************************************************************
	// synchroniser bit positions and reset image
	// ***************************************************************
	localparam int SYNC_SCLK = 0;
	localparam int SYNC_CS = 1;
	localparam int SYNC_HOLD = 2;
	localparam int SYNC_IO = 3;
	localparam logic [6:0] SYNC_INIT = 7'h7e;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CMD = 3'b001,
		S_ADDR = 3'b010,
		S_DUMMY = 3'b011,
		S_DATA = 3'b100,
		S_IGNORE = 3'b101
	} sfr_state_e;

	typedef enum logic [1:0] {
		W_SINGLE = 2'b00,
		W_DUAL = 2'b01,
		W_QUAD = 2'b10
	} sfr_width_e;

endpackage
`default_nettype wire

//--- sfr_sync.sv
`default_nettype none
module sfr_sync #(
	parameter int WIDTH = 7,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule
`default_nettype wire

//--- sfr_front_end.sv
`default_nettype none
module sfr_front_end
	import sfr_pkg::*;
#(
	parameter int ADDR_BITS = ADDR_BITS_DEFAULT
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic csN,
	input wire logic holdN,
	input wire logic [3:0] ioIn,
	output logic [3:0] ioOut,
	output logic [3:0] ioOe,
	input wire logic extendedAddressEnable,
	input wire logic quadCommandMode,
	input wire logic quadEnable,
	input wire logic dtrMode,
	input wire logic resetPinSelect,
	input wire logic writeInProgress,
	input wire logic [4:0] dummySingle,
	input wire logic [4:0] dummyDual,
	input wire logic [4:0] dummyQuad,
	output logic [ADDR_BITS-1:0] memAddr,
	input wire logic [7:0] memData,
	output logic frameActive,
	output logic paused,
	output logic continuousReadMode
);

	// ***************************************************************
	// parameter checks and constants
	// ***************************************************************
	if (ADDR_BITS < 1 || ADDR_BITS > 32) begin : g_bad_addr_bits
		$error("ADDR_BITS must lie between 1 and 32");
	end

	localparam logic [31:0] ADDR_MASK = 32'((64'h1 << ADDR_BITS) - 64'h1);

	typedef struct packed {
		sfr_state_e state;
		sfr_width_e width;
		logic [5:0] bitCnt;
		logic [7:0] opcode;
		logic [31:0] addr;
		logic wide;
		logic cont;
		logic [7:0] modeByte;
		logic [7:0] dout;
		logic [2:0] chunk;
		logic [3:0] ioOut;
		logic [3:0] ioOe;
		logic sclkPrev;
		logic paused;
	} sfr_front_s;

	sfr_front_s st_q;
	sfr_front_s st_d;
	logic [6:0] syncQ;
	logic sclkS;
	logic csHighS;
	logic holdS;
	logic [3:0] ioS;
	logic rise;
	logic fall;
	logic holdAllowed;
	logic [31:0] shifted;
	logic [7:0] byteNow;

	// ***************************************************************
	// helpers
	// ***************************************************************
	// shift lanes into a word, msb arriving first
	function automatic logic [31:0] shiftIn(input logic [31:0] v, input sfr_width_e w,
		input logic [3:0] io);
		case (w)
			W_DUAL: shiftIn = {v[29:0], io[1], io[0]};
			W_QUAD: shiftIn = {v[27:0], io};
			default: shiftIn = {v[30:0], io[0]};
		endcase
	endfunction

	// output enables used by a data phase
	function automatic logic [3:0] laneMask(input sfr_width_e w);
		case (w)
			W_DUAL: laneMask = 4'h3;
			W_QUAD: laneMask = 4'hf;
			default: laneMask = 4'h2;
		endcase
	endfunction

	// link clocks needed to carry the address
	function automatic logic [5:0] addrCycles(input logic wide, input sfr_width_e w);
		logic [5:0] bits;
		bits = wide ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
		case (w)
			W_DUAL: addrCycles = bits >> 1;
			W_QUAD: addrCycles = bits >> 2;
			default: addrCycles = bits;
		endcase
	endfunction

	// last chunk index of a byte
	function automatic logic [2:0] lastChunk(input sfr_width_e w);
		case (w)
			W_DUAL: lastChunk = 3'h3;
			W_QUAD: lastChunk = 3'h1;
			default: lastChunk = 3'h7;
		endcase
	endfunction

	// ***************************************************************
	// input synchronisation and edge finding
	// ***************************************************************
	sfr_sync #(
		.WIDTH(7),
		.INIT(SYNC_INIT)
	) u_sync (
		.mclk(mclk),
		.reset(reset),
		.d({ioIn, holdN, csN, sclk}),
		.q(syncQ)
	);

	assign sclkS = syncQ[SYNC_SCLK];
	assign csHighS = syncQ[SYNC_CS];
	assign holdS = syncQ[SYNC_HOLD];
	assign ioS = syncQ[SYNC_IO +: 4];
	assign rise = sclkS && !st_q.sclkPrev;
	assign fall = !sclkS && st_q.sclkPrev;
	assign holdAllowed = !dtrMode && !quadEnable && !resetPinSelect && !quadCommandMode;

	// ***************************************************************
	// frame sequencer
	// ***************************************************************
	always_comb begin
		st_d = st_q;
		shifted = '0;
		byteNow = '0;
		st_d.sclkPrev = sclkS;
		if (csHighS) begin
			// select high closes any frame
			st_d.state = S_IDLE;
			st_d.paused = 1'b0;
			st_d.bitCnt = '0;
			st_d.chunk = '0;
		end else begin
			// pause entry and exit on the hold input only while the clock sits low
			if (!holdAllowed) begin
				st_d.paused = 1'b0;
			end else if (!st_q.paused && !holdS && !sclkS && st_q.state != S_IDLE) begin
				st_d.paused = 1'b1;
			end else if (st_q.paused && holdS && !sclkS) begin
				st_d.paused = 1'b0;
			end
			if (st_q.state == S_IDLE) begin
				st_d.bitCnt = '0;
				st_d.chunk = '0;
				if (writeInProgress) begin
					st_d.state = S_IGNORE;
				end else if (st_q.cont) begin
					// continuous read skips the opcode
					st_d.state = S_ADDR;
					st_d.width = W_DUAL;
					st_d.addr = '0; // no stale high bits under a 3-byte address
					st_d.wide = (st_q.opcode == OP_DUAL_IO_WIDE) || extendedAddressEnable;
				end else begin
					st_d.state = S_CMD;
					st_d.width = quadCommandMode ? W_QUAD : W_SINGLE;
				end
			end else if (rise && !st_q.paused) begin
				case (st_q.state)
					S_CMD: begin
						shifted = shiftIn({24'h0, st_q.opcode}, st_q.width, ioS);
						st_d.opcode = shifted[7:0];
						st_d.bitCnt = st_q.bitCnt + 6'h1;
						if (st_q.bitCnt == (st_q.width == W_QUAD ? CMD_CYCLES_QUAD - 6'h1
							: CMD_CYCLES_SINGLE - 6'h1)) begin
							st_d.bitCnt = '0;
							st_d.state = S_ADDR;
							st_d.addr = '0;
							if (st_q.width == W_QUAD) begin
								// four-line command set
								case (shifted[7:0])
									OP_FAST_READ, OP_QUAD_IO: st_d.wide = extendedAddressEnable;
									OP_FAST_READ_WIDE: st_d.wide = 1'b1;
									OP_UNIQUE_ID, OP_INFO_ROW: st_d.wide = 1'b0;
									default: st_d.state = S_IGNORE;
								endcase
							end else begin
								// single-line command set
								case (shifted[7:0])
									OP_FAST_READ: st_d.wide = extendedAddressEnable;
									OP_FAST_READ_WIDE: st_d.wide = 1'b1;
									OP_DUAL_IO: begin
										st_d.wide = extendedAddressEnable;
										st_d.width = W_DUAL;
									end
									OP_DUAL_IO_WIDE: begin
										st_d.wide = 1'b1;
										st_d.width = W_DUAL;
									end
									default: st_d.state = S_IGNORE;
								endcase
							end
						end
					end
					S_ADDR: begin
						shifted = shiftIn(st_q.addr, st_q.width, ioS);
						st_d.addr = shifted;
						st_d.bitCnt = st_q.bitCnt + 6'h1;
						if (st_q.bitCnt == addrCycles(st_q.wide, st_q.width) - 6'h1) begin
							st_d.addr = shifted & ADDR_MASK;
							st_d.bitCnt = '0;
							st_d.modeByte = '0;
							st_d.state = S_DUMMY;
						end
					end
					S_DUMMY: begin
						st_d.bitCnt = st_q.bitCnt + 6'h1;
						if (st_q.width == W_DUAL && st_q.bitCnt < MODE_CYCLES) begin
							// mode byte in the first dummy cycles
							shifted = shiftIn({24'h0, st_q.modeByte}, W_DUAL, ioS);
							st_d.modeByte = shifted[7:0];
							if (st_q.bitCnt == MODE_CYCLES - 6'h1) begin
								st_d.cont = (shifted[7:4] == MODE_CONT_NIBBLE);
							end
						end
						if ({1'b0, st_q.bitCnt} == {2'b00, (st_q.width == W_DUAL ? dummyDual
							: st_q.width == W_QUAD ? dummyQuad : dummySingle)} - 7'h01) begin
							st_d.bitCnt = '0;
							st_d.chunk = '0;
							st_d.state = S_DATA;
						end
					end
					default: begin
					end
				endcase
			end else if (fall && !st_q.paused && st_q.state == S_DATA) begin
				// drive the next chunk of the current byte
				byteNow = (st_q.chunk == 3'h0) ? memData : st_q.dout;
				case (st_q.width)
					W_DUAL: begin
						st_d.ioOut = {2'b00, byteNow[7:6]};
						st_d.dout = {byteNow[5:0], 2'b00};
					end
					W_QUAD: begin
						st_d.ioOut = byteNow[7:4];
						st_d.dout = {byteNow[3:0], 4'h0};
					end
					default: begin
						st_d.ioOut = {2'b00, byteNow[7], 1'b0};
						st_d.dout = {byteNow[6:0], 1'b0};
					end
				endcase
				st_d.chunk = st_q.chunk + 3'h1;
				if (st_q.chunk == lastChunk(st_q.width)) begin
					st_d.chunk = '0;
					st_d.addr = (st_q.addr + 32'h1) & ADDR_MASK;
				end
			end
		end
		// lanes float outside a running, unpaused data phase
		st_d.ioOe = (st_d.state == S_DATA && !st_d.paused) ? laneMask(st_d.width) : 4'h0;
	end

	// state register
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign ioOut = st_q.ioOut;
	assign ioOe = st_q.ioOe;
	assign memAddr = st_q.addr[ADDR_BITS-1:0];
	assign frameActive = (st_q.state != S_IDLE);
	assign paused = st_q.paused;
	assign continuousReadMode = st_q.cont;

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	sequence s_select_released;
		csHighS ##1 1'b1;
	endsequence

	sequence s_mode_done;
		rise && !st_q.paused && st_q.state == S_DUMMY && st_q.width == W_DUAL
			&& st_q.bitCnt == MODE_CYCLES - 6'h1 && !csHighS;
	endsequence

	a_frame_end_idle: assert property (s_select_released
		|-> st_q.state == S_IDLE && ioOe == 4'h0)
		else $error("frame did not end on select high");

	a_wip_ignored: assert property (st_q.state == S_IDLE && !csHighS && writeInProgress
		|=> st_q.state == S_IGNORE ##1 (ioOe == 4'h0))
		else $error("read accepted during write in progress");

	a_pause_float: assert property (paused |-> ioOe == 4'h0)
		else $error("lanes driven while paused");

	a_pause_freeze: assert property (paused && $past(paused) && !csHighS
		|-> $stable(st_q.bitCnt) && $stable(st_q.addr) && $stable(st_q.chunk))
		else $error("frame advanced during pause");

	a_pause_disabled: assert property (!holdAllowed |=> !paused)
		else $error("pause taken while disabled");

	a_addr_wrap: assert property (fall && !st_q.paused && !csHighS && st_q.state == S_DATA
		&& st_q.chunk == lastChunk(st_q.width)
		|=> st_q.addr == (($past(st_q.addr) + 32'h1) & ADDR_MASK) && st_q.chunk == 3'h0)
		else $error("address did not advance after byte");

	a_cont_entry: assert property (s_mode_done
		|=> continuousReadMode == (st_q.modeByte[7:4] == MODE_CONT_NIBBLE))
		else $error("continuous read set on wrong nibble");

	a_single_lane: assert property (ioOe != 4'h0 && st_q.width == W_SINGLE |-> ioOe == 4'h2)
		else $error("single read drives wrong lanes");

	a_dual_lanes: assert property (ioOe != 4'h0 && st_q.width == W_DUAL |-> ioOe == 4'h3)
		else $error("dual read drives wrong lanes");

	a_quad_lanes: assert property (ioOe != 4'h0 && st_q.width == W_QUAD |-> ioOe == 4'hf)
		else $error("quad read drives wrong lanes");

	a_short_id_addr: assert property (st_q.state == S_ADDR && st_q.width == W_QUAD
		&& (st_q.opcode == OP_UNIQUE_ID || st_q.opcode == OP_INFO_ROW) |-> !st_q.wide)
		else $error("id read took a 4-byte address");

endmodule
`default_nettype wire

//--- sfr_host_model.sv
`default_nettype none
// ***************************************************************
// host side of the serial link
// ***************************************************************
module sfr_host_model (
	input wire logic mclk,
	input wire logic [3:0] ioOut,
	input wire logic [3:0] ioOe,
	output logic sclk,
	output logic csN,
	output logic holdN,
	output logic [3:0] ioIn,
	output logic [7:0] rxByte,
	output logic rxStrobe
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle levels: select off, clock parked low
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		holdN = 1'b1;
		ioIn = 4'h0;
		rxByte = 8'h00;
		rxStrobe = 1'b0;
	end
	task automatic waitc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// one link clock: lines set while low, device output taken just before the rise
	task automatic tick(input logic [3:0] drv, output logic [3:0] seen);
		sclk = 1'b0;
		ioIn = drv;
		waitc(4);
		seen = ioOut ^ ~ioOe; // undriven lanes read back inverted, never stale
		sclk = 1'b1;
		waitc(4);
	endtask
	// msb first, ln bits per clock, msb on the highest lane; spare lanes toggle
	task automatic send(input logic [31:0] v, input int nb, input int ln);
		logic [3:0] m;
		logic [3:0] s;
		m = 4'((1 << ln) - 1);
		for (int i = nb - ln; i >= 0; i -= ln) tick((4'(v >> i) & m) | (~m & ~ioIn), s);
	endtask
	// released lines toggle so a stale level never passes for data
	task automatic idle(input int n);
		logic [3:0] s;
		repeat (n) tick(~ioIn, s);
	endtask
	// collect n bytes, single mode reads lane 1
	task automatic rd(input int n, input int ln);
		logic [3:0] s;
		logic [7:0] b;
		for (int k = 0; k < n; k++) begin
			b = 8'h00;
			repeat (8 / ln) begin
				tick(~ioIn, s);
				b = (ln == 1) ? {b[6:0], s[1]} : (b << ln) | 8'(s & 4'((1 << ln) - 1));
			end
			rxByte = b;
			rxStrobe = ~rxStrobe;
		end
	endtask
	task automatic start();
		csN = 1'b0;
		waitc(4);
	endtask
	// clock parked low before select is dropped
	task automatic stop();
		sclk = 1'b0;
		waitc(2);
		csN = 1'b1;
		waitc(8);
	endtask
	// pause level changes only while the clock is low
	task automatic pause_set(input logic v);
		sclk = 1'b0;
		waitc(2);
		holdN = v;
		waitc(6);
	endtask
endmodule
`default_nettype wire

//--- sfr_front_end_tb.sv
`default_nettype none
// ***************************************************************
// self-checking bench for the read front end
// ***************************************************************
module sfr_front_end_tb;
	import sfr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, reset = 1'b1, sclk, csN, holdN, rxStrobe;
	logic [3:0] ioIn, ioOut, ioOe, s;
	logic ext = 1'b0, qcm = 1'b0, qen = 1'b0, write_in_progress = 1'b0, frameActive, paused, crm;
	logic dtr = 1'b0, rps = 1'b0;
	logic [4:0] dumS = DUMMY_SINGLE_DEFAULT, dumD = DUMMY_DUAL_DEFAULT, dumQ = DUMMY_QUAD_DEFAULT;
	logic [7:0] memAddr, memData, rxByte;
	logic [7:0] quadOps[4] = '{OP_FAST_READ, OP_QUAD_IO, OP_UNIQUE_ID, OP_INFO_ROW};
	logic [31:0] seed = 32'h0000001d;
	logic [7:0] expQ[$];
	int badCount = 0, nChecks = 0;
	// array contents follow the address so every byte is predictable
	assign memData = memAddr ^ 8'ha5;
	sfr_front_end #(.ADDR_BITS(8)) dut_u (.mclk(mclk), .reset(reset), .sclk(sclk), .csN(csN),
		.holdN(holdN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .extendedAddressEnable(ext),
		.quadCommandMode(qcm), .quadEnable(qen), .dtrMode(dtr), .resetPinSelect(rps),
		.writeInProgress(write_in_progress), .dummySingle(dumS), .dummyDual(dumD), .dummyQuad(dumQ),
		.memAddr(memAddr), .memData(memData), .frameActive(frameActive), .paused(paused),
		.continuousReadMode(crm));
	sfr_host_model host_u (.mclk(mclk), .ioOut(ioOut), .ioOe(ioOe), .sclk(sclk), .csN(csN),
		.holdN(holdN),
		.ioIn(ioIn), .rxByte(rxByte), .rxStrobe(rxStrobe));
	// 10 MHz system clock
	initial begin
		forever #50 mclk = ~mclk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] v);
		nChecks++;
		if (v !== e) begin
			badCount++;
			$display("[FAIL] %s expected %h seen %h", what, e, v);
		end
	endtask
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// each received byte is held against the oldest note
	always @(rxStrobe) begin
		if (!reset) begin
			if (expQ.size() == 0) chk("unexpected byte", 8'h00, 8'hff);
			else chk("read byte", expQ.pop_front(), rxByte);
		end
	end
	// a whole read frame; ol = 0 skips the opcode, two address lanes add the mode nibble
	task automatic frame(input logic [7:0] op, input int ol, input logic [31:0] a, input int ab,
		input int al, input logic [3:0] md, input int dum, input int dl, input int n);
		for (int k = 0; k < n; k++) expQ.push_back((a[7:0] + 8'(k)) ^ 8'ha5);
		host_u.start();
		if (ol > 0) host_u.send({24'h0, op}, 8, ol);
		host_u.send(a, ab, al);
		if (al == 2) begin
			host_u.send({28'h0, md}, 4, 2);
			host_u.idle(dum - 2);
		end else begin
			host_u.idle(dum);
		end
		host_u.rd(n, dl);
		host_u.stop();
	endtask
	// the hang guard
	initial begin
		repeat (60000) @(posedge mclk);
		badCount++;
		wrapUp();
	end
	initial begin
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		host_u.waitc(4);
		frame(OP_FAST_READ, 1, (rnd() & 32'hffffff00) | 32'h000000fe, 24, 1, 4'h0, 8, 1,
			3);
		ext = 1'b1;
		frame(OP_FAST_READ, 1, rnd(), 32, 1, 4'h0, 8, 1, 2);
		ext = 1'b0;
		frame(OP_FAST_READ_WIDE, 1, rnd(), 32, 1, 4'h0, 8, 1, 2);
		dumS = 5'h0a;
		frame(OP_FAST_READ, 1, rnd(), 24, 1, 4'h0, 10, 1, 2);
		dumS = DUMMY_SINGLE_DEFAULT;
		$display("done: single reads");
		frame(OP_DUAL_IO, 1, rnd(), 24, 2, 4'ha, 4, 2, 2);
		chk("continuous on", 8'h01, {7'h0, crm});
		frame(8'h00, 0, rnd(), 24, 2, 4'h3, 4, 2, 2);
		chk("continuous off", 8'h00, {7'h0, crm});
		frame(OP_DUAL_IO_WIDE, 1, rnd(), 32, 2, 4'h5, 4, 2, 2);
		chk("continuous stays off", 8'h00, {7'h0, crm});
		dumD = 5'h06;
		frame(OP_DUAL_IO, 1, rnd(), 24, 2, 4'h0, 6, 2, 2);
		dumD = DUMMY_DUAL_DEFAULT;
		$display("done: dual reads");
		qcm = 1'b1;
		foreach (quadOps[i]) begin
			frame(quadOps[i], 4, rnd(), 24, 4, 4'h0, 6, 4, 2);
		end
		frame(OP_FAST_READ_WIDE, 4, rnd(), 32, 4, 4'h0, 6, 4, 2);
		qcm = 1'b0;
		$display("done: four-line reads");
		write_in_progress = 1'b1;
		host_u.start();
		host_u.send({24'h0, OP_FAST_READ}, 8, 1);
		host_u.send(rnd(), 24, 1);
		host_u.idle(8);
		repeat (16) begin
			host_u.tick(~ioIn, s);
			chk("drive while busy", 8'h00, {4'h0, ioOe});
		end
		host_u.stop();
		write_in_progress = 1'b0;
		$display("done: busy refusal");
		expQ.push_back(8'h12 ^ 8'ha5);
		expQ.push_back(8'h13 ^ 8'ha5);
		expQ.push_back(8'h14 ^ 8'ha5);
		host_u.start();
		host_u.send({24'h0, OP_FAST_READ}, 8, 1);
		host_u.send(32'h12, 24, 1);
		host_u.idle(8);
		host_u.rd(1, 1);
		host_u.pause_set(1'b0);
		chk("paused", 8'h01, {7'h0, paused});
		chk("drive while paused", 8'h00, {4'h0, ioOe});
		host_u.idle(3);
		host_u.pause_set(1'b1);
		chk("resumed", 8'h00, {7'h0, paused});
		// quadEnable, dtrMode and resetPinSelect in turn must keep the pause from taking hold
		for (int j = 0; j < 3; j++) begin
			{qen, dtr, rps} = 3'h4 >> j;
			host_u.pause_set(1'b0);
			chk("pause blocked", 8'h00, {7'h0, paused});
			host_u.pause_set(1'b1);
		end
		{qen, dtr, rps} = 3'h0;
		host_u.rd(2, 1);
		host_u.stop();
		chk("frame ended", 8'h00, {7'h0, frameActive});
		$display("done: pause");
		frame(OP_DUAL_IO, 1, rnd(), 24, 2, 4'ha, 4, 2, 1);
		chk("continuous before reset", 8'h01, {7'h0, crm});
		reset = 1'b1;
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		host_u.waitc(4);
		chk("continuous after reset", 8'h00, {7'h0, crm});
		frame(OP_FAST_READ, 1, rnd(), 24, 1, 4'h0, 8, 1, 1);
		$display("done: reset");
		chk("bytes left", 8'h00, 8'(expQ.size()));
		wrapUp();
	end
endmodule
`default_nettype wire
